/* File: hdl/iflg_pkg.sv */
/*
 * Constants for the interrupt flag block: register map, field positions,
 * flag and source indices, vector table and machine-cycle timing.
 * Assumes a 32-bit AXI4-Lite register bus and one 200 MHz system clock.
 */
package iflg_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_KEYPAD = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_PRIORITY = 8'h10;
    localparam logic [7:0] OFS_POLL = 8'h14;

    // Request flag positions in the flag register
    localparam int NFLAGS = 17;
    localparam int F_EXT0 = 0;
    localparam int F_TMR0 = 1;
    localparam int F_EXT1 = 2;
    localparam int F_TMR1 = 3;
    localparam int F_SER_RX = 4;
    localparam int F_SER_TX = 5;
    localparam int F_TMR2 = 6;
    localparam int F_TWO_WIRE = 7;
    localparam int F_SUPPLY = 8;
    localparam int F_FW_DONE = 9;
    localparam int F_FW_FAULT = 10;
    localparam int F_FW_OVR = 11;
    localparam int F_WDT = 12;
    localparam int F_CONV = 13;
    localparam int F_CAPTURE = 14;
    localparam int F_BRAKE = 15;
    localparam int F_PERIOD = 16;

    // Sources, numbered in vector order; lower number wins a tie
    localparam int NSRC = 14;
    localparam logic [3:0] S_EXT0 = 4'h0;
    localparam logic [3:0] S_TMR0 = 4'h1;
    localparam logic [3:0] S_EXT1 = 4'h2;
    localparam logic [3:0] S_TMR1 = 4'h3;
    localparam logic [3:0] S_SERIAL = 4'h4;
    localparam logic [3:0] S_TMR2 = 4'h5;
    localparam logic [3:0] S_TWO_WIRE = 4'h6;
    localparam logic [3:0] S_KEYPAD = 4'h7;
    localparam logic [3:0] S_SUPPLY = 4'h8;
    localparam logic [3:0] S_FOUR_WIRE = 4'h9;
    localparam logic [3:0] S_WDT = 4'hA;
    localparam logic [3:0] S_CONV = 4'hB;
    localparam logic [3:0] S_CAPTURE = 4'hC;
    localparam logic [3:0] S_MOTOR = 4'hD;

    // Vector address = base + source * step; the motor vector sits apart
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_MOTOR = 16'h0073;
    localparam logic [15:0] VEC_STEP = 16'h0008;

    // Enable register: global enable sits above the per-source bits
    localparam int EN_GLOBAL = 15;
    // Keypad register fields
    localparam int KP_FLAGS_LSB = 0;
    localparam int KP_EN_LSB = 8;
    localparam int KP_EDGE_BIT = 16;
    // Control register fields
    localparam int CTL_EXT0_TRIG = 0;
    localparam int CTL_EXT1_TRIG = 1;
    localparam int CTL_BRAKE_POL = 2;
    // Poll register fields
    localparam int POLL_REQ = 0;
    localparam int POLL_LVL_LSB = 4;
    localparam int POLL_SRC_LSB = 8;
    localparam int POLL_VEC_LSB = 16;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Machine cycle length in system clocks
    localparam int MC_CLKS = 12;

endpackage : iflg_pkg

/* File: hdl/iflg_pin_if.sv */
/*
 * Carrier between the pin sampler and the flag logic: machine-cycle
 * strobe and the sampled pin levels and transitions.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface iflg_pin_if;
    logic mc_tick;
    logic [1:0] ext_low;
    logic [1:0] ext_fall;
    logic brake_lvl;
    logic [7:0] kp_low;
    logic [7:0] kp_change;

    modport producer (output mc_tick, ext_low, ext_fall, brake_lvl, kp_low, kp_change);
    modport consumer (input mc_tick, ext_low, ext_fall, brake_lvl, kp_low, kp_change);
endinterface : iflg_pin_if

/* File: hdl/iflg_pin_sampler.sv */
/*
 * Pin sampler: synchronises the external pins, samples them once per
 * machine cycle and reports levels and transitions between samples.
 * Assumes pins are asynchronous to aclk.
 */
`timescale 1ns/1ps
module iflg_pin_sampler
    import iflg_pkg::*;
#(
    parameter int MC_LEN = MC_CLKS
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins
    input wire logic [1:0] ext_pins,
    input wire logic brake_pin,
    input wire logic [7:0] keypad_pins,
    // Sampled view
    iflg_pin_if.producer pins
);
    localparam int NP = 11;
    localparam int CW = $clog2(MC_LEN);

    if (MC_LEN < 2)
    begin : g_bad_len
        $error("MC_LEN must be at least 2");
    end

    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [NP-1:0] smp;
    logic [NP-1:0] prev;
    logic [CW-1:0] mc_cnt;
    logic tick;

    // Two flops before anything reads a pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1 <= {NP{1'b1}};
            sync2 <= {NP{1'b1}};
        end
        else
        begin
            sync1 <= {keypad_pins, brake_pin, ext_pins};
            sync2 <= sync1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mc_cnt <= '0;
        else if (mc_cnt == CW'(MC_LEN - 1))
            mc_cnt <= '0;
        else
            mc_cnt <= mc_cnt + 1'b1;
    end

    assign tick = (mc_cnt == CW'(MC_LEN - 1));

    // One sample per machine cycle; pulses must span a full cycle to be seen
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            smp <= {NP{1'b1}};
            prev <= {NP{1'b1}};
            pins.mc_tick <= 1'b0;
        end
        else
        begin
            pins.mc_tick <= tick;
            if (tick)
            begin
                smp <= sync2;
                prev <= smp;
            end
        end
    end

    assign pins.ext_low = ~smp[1:0];
    assign pins.ext_fall = prev[1:0] & ~smp[1:0];
    assign pins.brake_lvl = smp[2];
    assign pins.kp_low = ~smp[10:3];
    assign pins.kp_change = prev[10:3] ^ smp[10:3];

endmodule : iflg_pin_sampler

/* File: hdl/iflg_flag_ctrl.sv */
/*
 * Interrupt request flag logic: sets, clears and gates the flags of
 * fourteen sources and polls them once per machine cycle for the core.
 * Assumes an AXI4-Lite master on aclk, peripheral event pulses on aclk,
 * and a core that pulses vec_ack with the source it vectored to.
 */
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
// Operation
// - Each external input has its own edge/level trigger-type bit.
// - Edge mode: high sample then low sample sets the external flag.
// - Edge mode: external flag clears when the core vectors to it.
// - Level mode: pin stays low until serviced; vectoring leaves flag.
// - Level mode: pin still low after service requests again.
// - Timer overflow sets its flag; vectoring to the timer clears it.
// - Watchdog timeout sets its flag; interrupt only when enabled.
// - Serial receive and transmit flags; cleared only by software.
// - Two-wire unit requests on each new state, when both enables set.
// - Four-wire transfer-done sets flag; only software writing zero clears.
// - Four-wire mode fault and overrun request on the same vector.
// - Conversion done sets flag; only software clears it.
// - Brake flag sets at pin level matching polarity; software clears.
// - Motor period counter underflow sets period flag; software clears.
// - Brake requests an interrupt only with motor-control enable set.
// - Eight keypad flags, per-pin enables, low or change mode.
// - Supply drop sets flag; requests with its enable and global enable.
// - Software may write every flag to one or zero.
// - Per-source enables plus a global enable that blocks all.
// - Fourteen sources, each with flag, enable, priority and vector.
// - Requests polled each machine cycle; nothing remembered between polls.
// - Fixed vectors: external 0 at 0003h, timer 0 000Bh, brake 0073h.
module iflg_flag_ctrl
    import iflg_pkg::*;
#(
    parameter int MC_LEN = MC_CLKS
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic brake_pin,
    input wire logic [7:0] keypad_pins,
    // Peripheral events, one-cycle pulses
    input wire logic tmr0_overflow,
    input wire logic tmr1_overflow,
    input wire logic tmr2_event,
    input wire logic capture_event,
    input wire logic watchdog_timeout,
    input wire logic serial_rx_done,
    input wire logic serial_tx_done,
    input wire logic two_wire_new_state,
    input wire logic four_wire_xfer_done,
    input wire logic four_wire_mode_fault,
    input wire logic four_wire_overrun,
    input wire logic conversion_done,
    input wire logic period_underflow,
    input wire logic supply_drop,
    // Core vectoring
    input wire logic vec_ack,
    input wire logic [3:0] vec_ack_source,
    output logic irq_request,
    output logic [3:0] irq_source,
    output logic [1:0] irq_level,
    output logic [15:0] irq_vector
);
    iflg_pin_if pins ();

    iflg_pin_sampler #(
        .MC_LEN(MC_LEN)
    ) u_sampler (
        .aclk(aclk),
        .aresetn(aresetn),
        .ext_pins({ext_irq1_pin, ext_irq0_pin}),
        .brake_pin(brake_pin),
        .keypad_pins(keypad_pins),
        .pins(pins)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return (a == OFS_FLAGS) || (a == OFS_KEYPAD) || (a == OFS_ENABLE) ||
               (a == OFS_CONTROL) || (a == OFS_PRIORITY) || (a == OFS_POLL);
    endfunction : mapped

    function automatic logic [15:0] vec_of(input logic [3:0] s);
        return (s == S_MOTOR) ? VEC_MOTOR : 16'(VEC_BASE + VEC_STEP * {12'h000, s});
    endfunction : vec_of

    // Software-visible state
    logic [NFLAGS-1:0] flags;
    logic [7:0] keypad_flags;
    logic [7:0] keypad_en;
    logic keypad_edge_mode;
    logic [NSRC-1:0] src_enable;
    logic global_irq_enable;
    logic ext0_trigger_type;
    logic ext1_trigger_type;
    logic brake_polarity_sel;
    logic [2*NSRC-1:0] priority_bits;

    // Bus write staging
    logic aw_held;
    logic w_held;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic [31:0] rd_word;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            wr_addr <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held <= 1'b0;
        else if (!aw_held && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held <= 1'b0;
        else if (!w_held && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Configuration registers
    logic [31:0] cfg_word;
    logic [31:0] cfg_wr;
    assign cfg_wr = merge((wr_addr == OFS_PRIORITY) ? {4'h0, priority_bits} : cfg_word, wr_data, wr_strb);
    always_comb
    begin
        cfg_word = 32'h0000_0000;
        cfg_word[EN_GLOBAL] = global_irq_enable;
        cfg_word[NSRC-1:0] = src_enable;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_enable <= REG_RESET[NSRC-1:0];
            global_irq_enable <= REG_RESET[0];
            ext0_trigger_type <= REG_RESET[0];
            ext1_trigger_type <= REG_RESET[0];
            brake_polarity_sel <= REG_RESET[0];
            priority_bits <= REG_RESET[2*NSRC-1:0];
            keypad_en <= REG_RESET[7:0];
            keypad_edge_mode <= REG_RESET[0];
        end
        else if (wr_fire)
        begin
            case (wr_addr)
                OFS_ENABLE:
                begin
                    src_enable <= cfg_wr[NSRC-1:0];
                    global_irq_enable <= cfg_wr[EN_GLOBAL];
                end
                OFS_CONTROL:
                begin
                    if (wr_strb[0])
                    begin
                        ext0_trigger_type <= wr_data[CTL_EXT0_TRIG];
                        ext1_trigger_type <= wr_data[CTL_EXT1_TRIG];
                        brake_polarity_sel <= wr_data[CTL_BRAKE_POL];
                    end
                end
                OFS_PRIORITY:
                    priority_bits <= cfg_wr[2*NSRC-1:0];
                OFS_KEYPAD:
                begin
                    if (wr_strb[1])
                        keypad_en <= wr_data[KP_EN_LSB +: 8];
                    if (wr_strb[2])
                        keypad_edge_mode <= wr_data[KP_EDGE_BIT];
                end
                default:
                begin
                end
            endcase
        end
    end

    // Hardware set and clear terms for each flag
    logic [NFLAGS-1:0] hw_set;
    logic [NFLAGS-1:0] hw_clr;
    logic [31:0] flag_wr;
    logic flag_we;

    assign flag_we = wr_fire && (wr_addr == OFS_FLAGS);
    assign flag_wr = merge({15'h0000, flags}, wr_data, wr_strb);

    always_comb
    begin
        hw_set = '0;
        hw_clr = '0;
        // Edge mode latches the fall; level mode mirrors the pin
        hw_set[F_EXT0] = pins.mc_tick && (ext0_trigger_type ? pins.ext_fall[0] : pins.ext_low[0]);
        hw_set[F_EXT1] = pins.mc_tick && (ext1_trigger_type ? pins.ext_fall[1] : pins.ext_low[1]);
        hw_clr[F_EXT0] = ext0_trigger_type ? (vec_ack && vec_ack_source == S_EXT0)
                                           : (pins.mc_tick && !pins.ext_low[0]);
        hw_clr[F_EXT1] = ext1_trigger_type ? (vec_ack && vec_ack_source == S_EXT1)
                                           : (pins.mc_tick && !pins.ext_low[1]);
        hw_set[F_TMR0] = tmr0_overflow;
        hw_set[F_TMR1] = tmr1_overflow;
        hw_clr[F_TMR0] = vec_ack && (vec_ack_source == S_TMR0);
        hw_clr[F_TMR1] = vec_ack && (vec_ack_source == S_TMR1);
        hw_set[F_SER_RX] = serial_rx_done;
        hw_set[F_SER_TX] = serial_tx_done;
        hw_set[F_TMR2] = tmr2_event;
        hw_set[F_TWO_WIRE] = two_wire_new_state;
        hw_set[F_SUPPLY] = supply_drop;
        hw_set[F_FW_DONE] = four_wire_xfer_done;
        hw_set[F_FW_FAULT] = four_wire_mode_fault;
        hw_set[F_FW_OVR] = four_wire_overrun;
        hw_set[F_WDT] = watchdog_timeout;
        hw_set[F_CONV] = conversion_done;
        hw_set[F_CAPTURE] = capture_event;
        hw_set[F_BRAKE] = pins.mc_tick && (pins.brake_lvl == brake_polarity_sel);
        hw_set[F_PERIOD] = period_underflow;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NFLAGS; gi++)
        begin : g_flag
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    flags[gi] <= REG_RESET[0];
                else if (hw_set[gi])
                    flags[gi] <= 1'b1;
                else if (flag_we)
                    flags[gi] <= flag_wr[gi];
                else if (hw_clr[gi])
                    flags[gi] <= 1'b0;
            end
        end
    endgenerate

    // Keypad flags, one per pin
    logic [7:0] kp_set;
    logic [31:0] kp_word;
    assign kp_set = {8{pins.mc_tick}} & keypad_en & (keypad_edge_mode ? pins.kp_change : pins.kp_low);
    assign kp_word = {15'h0000, keypad_edge_mode, keypad_en, keypad_flags};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            keypad_flags <= REG_RESET[7:0];
        else if (wr_fire && wr_addr == OFS_KEYPAD && wr_strb[0])
            keypad_flags <= kp_set | wr_data[KP_FLAGS_LSB +: 8];
        else
            keypad_flags <= keypad_flags | kp_set;
    end

    // Source requests after individual gating
    logic [NSRC-1:0] src_flag;
    logic [NSRC-1:0] src_req;
    always_comb
    begin
        src_flag = '0;
        src_flag[S_EXT0] = flags[F_EXT0];
        src_flag[S_TMR0] = flags[F_TMR0];
        src_flag[S_EXT1] = flags[F_EXT1];
        src_flag[S_TMR1] = flags[F_TMR1];
        src_flag[S_SERIAL] = flags[F_SER_RX] | flags[F_SER_TX];
        src_flag[S_TMR2] = flags[F_TMR2];
        src_flag[S_TWO_WIRE] = flags[F_TWO_WIRE];
        src_flag[S_KEYPAD] = |keypad_flags;
        src_flag[S_SUPPLY] = flags[F_SUPPLY];
        src_flag[S_FOUR_WIRE] = flags[F_FW_DONE] | flags[F_FW_FAULT] | flags[F_FW_OVR];
        src_flag[S_WDT] = flags[F_WDT];
        src_flag[S_CONV] = flags[F_CONV];
        src_flag[S_CAPTURE] = flags[F_CAPTURE];
        src_flag[S_MOTOR] = flags[F_BRAKE] | flags[F_PERIOD];
    end

    assign src_req = src_flag & src_enable & {NSRC{global_irq_enable}};

    // Priority resolution: highest level, then lowest source number
    logic found;
    logic [3:0] best_src;
    logic [1:0] best_lvl;
    always_comb
    begin
        found = 1'b0;
        best_src = 4'h0;
        best_lvl = 2'h0;
        for (int s = NSRC - 1; s >= 0; s--)
        begin
            if (src_req[s] && (!found || priority_bits[2*s +: 2] >= best_lvl))
            begin
                found = 1'b1;
                best_src = 4'(s);
                best_lvl = priority_bits[2*s +: 2];
            end
        end
    end

    // Each poll replaces the last; an unserviced request is not held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_request <= 1'b0;
            irq_source <= 4'h0;
            irq_level <= 2'h0;
            irq_vector <= 16'h0000;
        end
        else if (pins.mc_tick)
        begin
            irq_request <= found;
            irq_source <= best_src;
            irq_level <= best_lvl;
            irq_vector <= found ? vec_of(best_src) : 16'h0000;
        end
    end

    // Read path
    always_comb
    begin
        case (s_axi_araddr)
            OFS_FLAGS:
                rd_word = {15'h0000, flags};
            OFS_KEYPAD:
                rd_word = kp_word;
            OFS_ENABLE:
                rd_word = cfg_word;
            OFS_CONTROL:
                rd_word = {29'h0000_0000, brake_polarity_sel, ext1_trigger_type, ext0_trigger_type};
            OFS_PRIORITY:
                rd_word = {4'h0, priority_bits};
            OFS_POLL:
                rd_word = {irq_vector, 4'h0, irq_source, 2'h0, irq_level, 3'h0, irq_request};
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

endmodule : iflg_flag_ctrl

/* File: sim/iflg_flag_ctrl_asserts.sv */
/* Checker on the flag block's bus and vector ports.
   Assumes it is bound to iflg_flag_ctrl. */
`timescale 1ns/1ps
module iflg_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Vectoring
    input wire logic irq_request,
    input wire logic [3:0] irq_source,
    input wire logic [15:0] irq_vector
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped early");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready during response");
    a_vec_ext0: assert property (irq_request && irq_source == 4'h0 |-> irq_vector == 16'h0003)
        else $error("ext0 vector");
    a_vec_tmr0: assert property (irq_request && irq_source == 4'h1 |-> irq_vector == 16'h000B)
        else $error("tmr0 vector");
    a_vec_brake: assert property (irq_request && irq_source == 4'hD |-> irq_vector == 16'h0073)
        else $error("brake vector");
    a_src_range: assert property (irq_request |-> irq_source < 4'hE)
        else $error("source out of range");
    a_poll_hold: assert property ($changed(irq_request) |=> $stable(irq_request))
        else $error("request changed between polls");
    c_ext0: cover property (irq_request && irq_source == 4'h0);
    c_brake: cover property (irq_request && irq_source == 4'hD);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : iflg_checker

/* File: sim/iflg_core_model.sv */
/* Core vectoring model: one vec_ack per take pulse.
   Assumes the design polls on aclk. */
`timescale 1ns/1ps
module iflg_core_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench control
    input wire logic take,
    // Vectoring
    input wire logic irq_request,
    input wire logic [3:0] irq_source,
    output logic vec_ack,
    output logic [3:0] vec_ack_source
);
    logic armed;
    // Single shot, so a stale poll is not acknowledged twice
    always_ff @(posedge aclk)
    begin
        vec_ack <= 1'b0;
        if (!aresetn)
            armed <= 1'b0;
        else if (take)
            armed <= 1'b1;
        else if (armed && irq_request)
        begin
            vec_ack <= 1'b1;
            vec_ack_source <= irq_source;
            armed <= 1'b0;
        end
    end
endmodule : iflg_core_model

/* File: sim/iflg_flag_ctrl_bench.sv */
/* Bench for iflg_flag_ctrl: registers, events, pins, vectors.
   Assumes MC_LEN of 4 and the core model. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module iflg_flag_ctrl_bench
    import iflg_pkg::*;
;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, e0 = 1, bk = 1, take = 0;
    logic awr, wrd, bv, arr, rv, ack, req;
    logic [7:0] aa = 0, ra = 0, kp = 8'hFF;
    logic [31:0] wd = 0, rdata;
    logic [13:0] ev = 0;
    logic [1:0] bresp, rresp, lvl;
    logic [3:0] ack_src, src;
    logic [15:0] vec;
    int n_mismatch = 0, checks_done = 0;
    iflg_flag_ctrl #(.MC_LEN(4)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .ext_irq0_pin(e0), .ext_irq1_pin(1'b1), .brake_pin(bk), .keypad_pins(kp),
        .tmr0_overflow(ev[0]), .tmr1_overflow(ev[1]), .serial_rx_done(ev[2]), .serial_tx_done(ev[3]),
        .tmr2_event(ev[4]), .two_wire_new_state(ev[5]), .supply_drop(ev[6]), .four_wire_xfer_done(ev[7]),
        .four_wire_mode_fault(ev[8]), .four_wire_overrun(ev[9]), .watchdog_timeout(ev[10]),
        .conversion_done(ev[11]), .capture_event(ev[12]), .period_underflow(ev[13]), .vec_ack(ack),
        .vec_ack_source(ack_src), .irq_request(req), .irq_source(src), .irq_level(lvl), .irq_vector(vec));
    iflg_core_model i_core (.aclk(aclk), .aresetn(aresetn), .take(take), .irq_request(req),
        .irq_source(src), .vec_ack(ack), .vec_ack_source(ack_src));
    initial
        forever #2.5 aclk = ~aclk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end
        while (!bv);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        ra <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end
        while (!rv);
        `CHK("rdata", e, rdata)
        `CHK("rresp", er, rresp)
    endtask : rd
    task automatic core_ack;
        take <= 1'b1;
        @(posedge aclk);
        take <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask : core_ack
    task automatic t_events;
        int fb[14] = '{1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 16};
        for (int i = 0; i < 14; i++)
        begin
            wr(OFS_FLAGS, 32'h0);
            ev[i] <= 1'b1;
            @(posedge aclk);
            ev[i] <= 1'b0;
            rd(OFS_FLAGS, 32'h1 << fb[i], RESP_OKAY);
        end
    endtask : t_events
    task automatic t_ext0;
        wr(OFS_FLAGS, 32'h0);
        wr(OFS_CONTROL, 32'h1);
        wr(OFS_ENABLE, 32'h8001);
        e0 <= 1'b0;
        repeat (12) @(posedge aclk);
        rd(OFS_POLL, 32'h0003_0001, RESP_OKAY);
        core_ack;
        rd(OFS_FLAGS, 32'h0, RESP_OKAY);
        wr(OFS_CONTROL, 32'h0);
        core_ack;
        rd(OFS_FLAGS, 32'h1, RESP_OKAY);
        e0 <= 1'b1;
    endtask : t_ext0
    task automatic t_global;
        wr(OFS_FLAGS, 32'h2002);
        wr(OFS_ENABLE, 32'h0802);
        repeat (12) @(posedge aclk);
        rd(OFS_POLL, 32'h0, RESP_OKAY);
        wr(OFS_ENABLE, 32'h8802);
        repeat (12) @(posedge aclk);
        rd(OFS_POLL, 32'h000B_0101, RESP_OKAY);
        wr(OFS_PRIORITY, 32'hC00000);
        repeat (12) @(posedge aclk);
        rd(OFS_POLL, 32'h005B_0B31, RESP_OKAY);
        wr(OFS_FLAGS, 32'h0);
        rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    endtask : t_global
    task automatic t_brake;
        wr(OFS_ENABLE, 32'hA000);
        wr(OFS_CONTROL, 32'h4);
        repeat (12) @(posedge aclk);
        rd(OFS_POLL, 32'h0073_0D01, RESP_OKAY);
        bk <= 1'b0;
        repeat (12) @(posedge aclk);
        wr(OFS_FLAGS, 32'h0);
        rd(OFS_FLAGS, 32'h0, RESP_OKAY);
        wr(OFS_KEYPAD, 32'h400);
        kp <= 8'hFB;
        repeat (12) @(posedge aclk);
        rd(OFS_KEYPAD, 32'h404, RESP_OKAY);
    endtask : t_brake
    task automatic conclude;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        t_events;
        t_ext0;
        t_global;
        t_brake;
        conclude;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        conclude;
    end
endmodule : iflg_flag_ctrl_bench
bind iflg_flag_ctrl iflg_checker i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_request(irq_request), .irq_source(irq_source), .irq_vector(irq_vector));
